// File: src/rldac_pkg.sv
package rldac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int REG_W     = 8;
  localparam int LEVEL_W   = 5;
  localparam int PSS_W     = 2;
  localparam int NUM_SRC   = 3;
  localparam int WORD_LSB  = 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL_MAIN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_SELECT = 8'h04;

  localparam logic [REG_W-1:0] CONTROL_MAIN_RESET = 8'h00;
  localparam logic [REG_W-1:0] LEVEL_SELECT_RESET = 8'h00;

  // Field positions in ladder_control_main
  localparam int ENABLE_BIT    = 7;
  localparam int LOW_POWER_BIT = 6;
  localparam int PIN_OE_BIT    = 5;
  localparam int PSS_LSB       = 2;
  // Field position in ladder_level_select
  localparam int LEVEL_LSB     = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [PSS_W-1:0] PSS_SUPPLY     = 2'h0;
  localparam logic [PSS_W-1:0] PSS_EXT_REF    = 2'h1;
  localparam logic [PSS_W-1:0] PSS_FIXED_BUF  = 2'h2;
  localparam logic [PSS_W-1:0] PSS_RESERVED   = 2'h3;

  localparam int SRC_SUPPLY    = 0;
  localparam int SRC_EXT_REF   = 1;
  localparam int SRC_FIXED_BUF = 2;

  localparam logic [NUM_SRC-1:0] SRC_NONE = 3'h0;

  localparam logic [LEVEL_W-1:0] LEVEL_ALL_ONES = 5'h1f;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO     = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               ladder_enable;
    logic               low_power_source_select;
    logic               pin_output_enable;
    logic [PSS_W-1:0]   positive_source_select;
    logic [LEVEL_W-1:0] level_code;
  } rldac_cfg_type;

  typedef struct packed {
    logic               ladder_on;
    logic               pos_connect;
    logic               neg_connect;
    logic [NUM_SRC-1:0] pos_source_onehot;
    logic [LEVEL_W-1:0] tap_code;
    logic               clamp_pos;
    logic               clamp_neg;
    logic               pin_route;
  } rldac_ctrl_type;

  localparam rldac_ctrl_type CTRL_RESET = '0;

endpackage : rldac_pkg

// File: src/rldac_sync2.sv
`timescale 1ns/1ps
module rldac_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) begin
      $error("rldac_sync2: WIDTH must be at least 1");
    end
  end

  // First stage is read by the second stage only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : rldac_sync2

// File: src/rldac_decode.sv
`timescale 1ns/1ps
module rldac_decode
  import rldac_pkg::*;
(
  input  rldac_cfg_type  cfg,
  output rldac_ctrl_type ctrl
);

  always_comb begin
    ctrl = CTRL_RESET;
    // Reserved code leaves every positive source open
    case (cfg.positive_source_select)
      PSS_SUPPLY:    ctrl.pos_source_onehot[SRC_SUPPLY]    = 1'b1;
      PSS_EXT_REF:   ctrl.pos_source_onehot[SRC_EXT_REF]   = 1'b1;
      PSS_FIXED_BUF: ctrl.pos_source_onehot[SRC_FIXED_BUF] = 1'b1;
      PSS_RESERVED:  ctrl.pos_source_onehot = SRC_NONE;
      default:       ctrl.pos_source_onehot = SRC_NONE;
    endcase
    if (cfg.ladder_enable) begin
      // Negative end is ground, so the tap code alone sets the fraction
      ctrl.ladder_on   = 1'b1;
      ctrl.pos_connect = 1'b1;
      ctrl.neg_connect = 1'b1;
      ctrl.tap_code    = cfg.level_code;
    end else begin
      // Disabled: one end is always open, so no ladder current flows
      ctrl.ladder_on   = 1'b0;
      ctrl.pos_connect = cfg.low_power_source_select;
      ctrl.neg_connect = !cfg.low_power_source_select;
      ctrl.tap_code    = cfg.level_code;
      ctrl.clamp_pos   = cfg.low_power_source_select && (cfg.level_code == LEVEL_ALL_ONES);
      ctrl.clamp_neg   = !cfg.low_power_source_select && (cfg.level_code == LEVEL_ZERO);
    end
    ctrl.pin_route = cfg.pin_output_enable;
  end

endmodule : rldac_decode

// File: src/rldac_top.sv
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - The ladder is powered only while the enable bit 7 of the main control register is one.
// - A 5-bit level code in bits 4 to 0 of the level register picks one of 32 levels.
// - When enabled the tap is ground plus the source span times the code over 32.
// - Disabled, low-power select bit 6 set keeps the positive end and opens the negative end, cleared the reverse.
// - Disabled, low-power select set and code all ones clamp the output to the positive source.
// - Disabled, low-power select clear and code all zeros clamp the output to ground with no current.
// - Output enable bit 5 routes the ladder voltage onto the dedicated pin, and zero disconnects it.
// - While routed, the pin's digital driver is forced off and its input detector is disabled.
// - A digital read of the routed pin always returns zero.
// - Source select bits 3 to 2 choose supply for 00, reference pin for 01, fixed buffer for 10, 11 reserved.
// - Wake-up from sleep leaves every bit of the main control register unchanged.
// - Any reset disables the ladder, frees the pin, clears the level code and zeroes all control bits.
// - Unimplemented bits read as zero: main bits 4, 1, 0 and level bits 7 to 5.
module rldac_top
  import rldac_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Analog ladder controls
  output logic                     ladder_on,
  output logic                     pos_connect,
  output logic                     neg_connect,
  output logic [NUM_SRC-1:0]       pos_source_onehot,
  output logic [LEVEL_W-1:0]       tap_code,
  output logic                     clamp_pos,
  output logic                     clamp_neg,
  output logic                     pin_route,
  // Dedicated output pin, digital side
  input  wire logic                gpio_pin_out,
  input  wire logic                gpio_pin_oe,
  input  wire logic                reference_output_pin_i,
  output logic                     reference_output_pin_o,
  output logic                     reference_output_pin_oe,
  output logic                     pin_input_detect_en,
  output logic                     gpio_pin_read
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                aw_held_ff;
  logic [ADDR_W-1:0]   aw_addr_ff;
  logic                w_held_ff;
  logic [DATA_W-1:0]   w_data_ff;
  logic                w_strb0_ff;
  logic                awready_ff;
  logic                wready_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [1:0]          rresp_ff;
  logic [DATA_W-1:0]   rdata_ff;

  logic [REG_W-1:0]    control_main_ff;
  logic [REG_W-1:0]    level_select_ff;

  rldac_cfg_type       cfg;
  rldac_ctrl_type      nxt_ctrl;
  rldac_ctrl_type      ctrl_ff;

  logic                pin_sync;
  logic                pin_do_ff;
  logic                pin_oe_ff;
  logic                pin_ie_ff;
  logic                pin_read_ff;

  logic                do_write;
  logic [ADDR_W-1:0]   wr_word_addr;
  logic                wr_hit_main;
  logic                wr_hit_level;
  logic [ADDR_W-1:0]   rd_word_addr;
  logic                rd_take;
  logic [REG_W-1:0]    nxt_rd_byte;
  logic                nxt_rd_err;

  // Implemented bits only; everything else is dropped on write and reads zero
  localparam logic [REG_W-1:0] MAIN_IMPL_MASK =
    REG_W'((1 << ENABLE_BIT) | (1 << LOW_POWER_BIT) | (1 << PIN_OE_BIT) | (((1 << PSS_W) - 1) << PSS_LSB));
  localparam logic [REG_W-1:0] LEVEL_IMPL_MASK = REG_W'(((1 << LEVEL_W) - 1) << LEVEL_LSB);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_ff  <= 1'b0;
      w_data_ff  <= '0;
      w_strb0_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_held_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata;
      w_strb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Ready drops once a beat is held, so a second write waits for the response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      awready_ff <= !aw_held_ff && !(s_axi_awvalid && awready_ff) && !bvalid_ff && !do_write;
      wready_ff  <= !w_held_ff && !(s_axi_wvalid && wready_ff) && !bvalid_ff && !do_write;
    end
  end

  assign do_write     = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_word_addr = {aw_addr_ff[ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
  assign wr_hit_main  = (wr_word_addr == OFS_CONTROL_MAIN);
  assign wr_hit_level = (wr_word_addr == OFS_LEVEL_SELECT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_hit_main || wr_hit_level) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only reset and bus writes touch these; sleep and wake have no path here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_main_ff <= CONTROL_MAIN_RESET;
    end else if (do_write && wr_hit_main && w_strb0_ff) begin
      control_main_ff <= w_data_ff[REG_W-1:0] & MAIN_IMPL_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_select_ff <= LEVEL_SELECT_RESET;
    end else if (do_write && wr_hit_level && w_strb0_ff) begin
      level_select_ff <= w_data_ff[REG_W-1:0] & LEVEL_IMPL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign rd_take      = s_axi_arvalid && arready_ff;
  assign rd_word_addr = {s_axi_araddr[ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};

  always_comb begin
    nxt_rd_byte = '0;
    nxt_rd_err  = 1'b0;
    case (rd_word_addr)
      OFS_CONTROL_MAIN: nxt_rd_byte = control_main_ff & MAIN_IMPL_MASK;
      OFS_LEVEL_SELECT: nxt_rd_byte = level_select_ff & LEVEL_IMPL_MASK;
      default:          nxt_rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
    end else begin
      arready_ff <= !rvalid_ff && !rd_take;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= '0;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= nxt_rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_ff  <= {{(DATA_W-REG_W){1'b0}}, nxt_rd_byte};
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Ladder decode
  // ----------------------------------------------------------------
  // One process owns the whole carrier, so every field has a single driver
  always_comb begin
    cfg.ladder_enable           = control_main_ff[ENABLE_BIT];
    cfg.low_power_source_select = control_main_ff[LOW_POWER_BIT];
    cfg.pin_output_enable       = control_main_ff[PIN_OE_BIT];
    cfg.positive_source_select  = control_main_ff[PSS_LSB +: PSS_W];
    cfg.level_code              = level_select_ff[LEVEL_LSB +: LEVEL_W];
  end

  rldac_decode u_decode (
    .cfg  (cfg),
    .ctrl (nxt_ctrl)
  );

  // Registered so the analog side sees glitch-free levels, one edge after the write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Dedicated pin override
  // ----------------------------------------------------------------
  rldac_sync2 #(
    .WIDTH (1)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (reference_output_pin_i),
    .sync_out (pin_sync)
  );

  // Override follows the decoded route nxt_ctrl.pin_route, so it switches on the same edge as pin_route and they never overlap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_do_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      pin_ie_ff <= 1'b1;
    end else if (nxt_ctrl.pin_route) begin
      pin_do_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      pin_ie_ff <= 1'b0;
    end else begin
      pin_do_ff <= gpio_pin_out;
      pin_oe_ff <= gpio_pin_oe;
      pin_ie_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_read_ff <= 1'b0;
    end else if (nxt_ctrl.pin_route) begin
      pin_read_ff <= 1'b0;
    end else begin
      pin_read_ff <= pin_sync;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  assign ladder_on         = ctrl_ff.ladder_on;
  assign pos_connect       = ctrl_ff.pos_connect;
  assign neg_connect       = ctrl_ff.neg_connect;
  assign pos_source_onehot = ctrl_ff.pos_source_onehot;
  assign tap_code          = ctrl_ff.tap_code;
  assign clamp_pos         = ctrl_ff.clamp_pos;
  assign clamp_neg         = ctrl_ff.clamp_neg;
  assign pin_route         = ctrl_ff.pin_route;

  assign reference_output_pin_o  = pin_do_ff;
  assign reference_output_pin_oe = pin_oe_ff;
  assign pin_input_detect_en     = pin_ie_ff;
  assign gpio_pin_read           = pin_read_ff;

endmodule : rldac_top

// File: verif/rldac_pad_model.sv
`timescale 1ns/1ps
module rldac_pad_model (
  input  wire logic sys_clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic pin_route,
  input  wire logic ext_level,
  output logic      pin_level
);
  logic wobble_ff = 1'b0;

  always @(posedge sys_clk) begin
    wobble_ff <= ~wobble_ff;
  end

  // Routed pad carries an analog level, so the digital side sees noise
  assign pin_level = pin_oe ? pin_o : (pin_route ? wobble_ff : ext_level);
endmodule : rldac_pad_model

// File: verif/rldac_chk.sv
`timescale 1ns/1ps
module rldac_chk
  import rldac_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic [DATA_W-1:0]  s_axi_rdata,
  input wire logic               s_axi_bvalid,
  input wire logic               ladder_on,
  input wire logic               pos_connect,
  input wire logic               neg_connect,
  input wire logic [NUM_SRC-1:0] pos_source_onehot,
  input wire logic [LEVEL_W-1:0] tap_code,
  input wire logic               clamp_pos,
  input wire logic               clamp_neg,
  input wire logic               pin_route,
  input wire logic               reference_output_pin_o,
  input wire logic               reference_output_pin_oe,
  input wire logic               pin_input_detect_en,
  input wire logic               gpio_pin_read
);
  // First edge after reset loads the decode, so some checks wait for it
  logic live_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) live_ff <= 1'b0;
    else        live_ff <= 1'b1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_answer;
    s_axi_rvalid && s_axi_rdata[DATA_W-1:REG_W] == '0;
  endsequence

  enable_ends_a : assert property (ladder_on |-> pos_connect && neg_connect)
    else $error("ladder on without both ends");
  low_power_a : assert property (live_ff && !ladder_on |-> pos_connect != neg_connect)
    else $error("low power ends wrong");
  clamp_pos_a : assert property (clamp_pos == (!ladder_on && pos_connect && tap_code == LEVEL_ALL_ONES))
    else $error("positive clamp wrong");
  clamp_neg_a : assert property (clamp_neg == (!ladder_on && neg_connect && tap_code == LEVEL_ZERO))
    else $error("negative clamp wrong");
  source_sel_a : assert property ($onehot0(pos_source_onehot))
    else $error("several sources selected");
  pin_override_a : assert property (pin_route |-> !reference_output_pin_oe && !reference_output_pin_o
                                    && !pin_input_detect_en)
    else $error("routed pin still digital");
  pin_read_a : assert property (pin_route |-> !gpio_pin_read)
    else $error("routed pin read not zero");
  write_only_a : assert property (live_ff && $past(live_ff) && $changed({ladder_on, pos_connect, neg_connect,
      pos_source_onehot, tap_code, clamp_pos, clamp_neg, pin_route}) |-> $past(s_axi_bvalid))
    else $error("controls changed without write");
  reset_clear_a : assert property ($rose(live_ff) |-> !ladder_on && !pin_route && tap_code == LEVEL_ZERO
                                   && clamp_neg)
    else $error("reset state wrong");
  read_answer_a : assert property (ar_take |=> rd_answer)
    else $error("read answer wrong");
endmodule : rldac_chk

bind rldac_top rldac_chk u_chk (.sys_clk, .rst_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_bvalid, .ladder_on, .pos_connect, .neg_connect, .pos_source_onehot, .tap_code,
  .clamp_pos, .clamp_neg, .pin_route, .reference_output_pin_o, .reference_output_pin_oe,
  .pin_input_detect_en, .gpio_pin_read);

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rldac_pkg::*;
  logic                sys_clk, rst_n, ext_level;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [2:0]          s_axi_awprot, s_axi_arprot;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata, rd;
  logic [DATA_W/8-1:0] s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, resp;
  logic                ladder_on, pos_connect, neg_connect, clamp_pos, clamp_neg, pin_route;
  logic [NUM_SRC-1:0]  pos_source_onehot;
  logic [LEVEL_W-1:0]  tap_code;
  logic                gpio_pin_out, gpio_pin_oe, reference_output_pin_i, reference_output_pin_o;
  logic                reference_output_pin_oe, pin_input_detect_en, gpio_pin_read;
  logic [7:0]          m, l;
  logic [7:0]          cm [4] = '{8'h40, 8'h00, 8'he0, 8'h6c};
  logic [7:0]          cl [4] = '{8'h1f, 8'h00, 8'hff, 8'he0};
  int                  error_cnt, comparisons;

  rldac_top DUT (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ladder_on, .pos_connect, .neg_connect, .pos_source_onehot, .tap_code,
    .clamp_pos, .clamp_neg, .pin_route, .gpio_pin_out, .gpio_pin_oe, .reference_output_pin_i,
    .reference_output_pin_o, .reference_output_pin_oe, .pin_input_detect_en, .gpio_pin_read);
  rldac_pad_model u_pad (.sys_clk, .pin_o(reference_output_pin_o), .pin_oe(reference_output_pin_oe),
    .pin_route, .ext_level, .pin_level(reference_output_pin_i));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  function automatic rldac_ctrl_type exp_ctrl(input logic [7:0] mm, input logic [7:0] ll);
    rldac_ctrl_type c;
    c.ladder_on         = mm[7];
    c.pos_connect       = mm[7] | mm[6];
    c.neg_connect       = mm[7] | !mm[6];
    c.pos_source_onehot = (mm[3:2] == 2'h3) ? 3'h0 : 3'h1 << mm[3:2];
    c.tap_code          = ll[4:0];
    c.clamp_pos         = !mm[7] & mm[6] & (ll[4:0] == 5'h1f);
    c.clamp_neg         = !mm[7] & !mm[6] & (ll[4:0] == 5'h00);
    c.pin_route         = mm[5];
    return c;
  endfunction : exp_ctrl

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic check_all();
    chk(32'({ladder_on, pos_connect, neg_connect, pos_source_onehot, tap_code, clamp_pos, clamp_neg,
             pin_route}), 32'(exp_ctrl(m, l)));
    chk({reference_output_pin_oe, reference_output_pin_o, pin_input_detect_en, gpio_pin_read},
        m[5] ? 4'h0 : {gpio_pin_oe, gpio_pin_out, 1'b1, gpio_pin_oe ? gpio_pin_out : ext_level});
    axi_rd(OFS_CONTROL_MAIN, rd, resp);
    chk(rd, {24'h0, m & 8'hec});
    axi_rd(OFS_LEVEL_SELECT, rd, resp);
    chk(rd, {24'h0, l & 8'h1f});
  endtask : check_all

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    {rst_n, ext_level, gpio_pin_out, gpio_pin_oe, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    m = 8'h00;
    l = 8'h00;
    void'($urandom(32'h3a997543));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check_all();
    for (int i = 0; i < 40; i++) begin
      m = (i < 4) ? cm[i] : 8'($urandom);
      l = (i < 4) ? cl[i] : 8'($urandom);
      if (i >= 4) m[3:2] = 2'(i);
      @(posedge sys_clk);
      gpio_pin_out <= 1'($urandom);
      gpio_pin_oe  <= 1'($urandom);
      ext_level    <= 1'($urandom);
      rd = $urandom;
      rd[7:0] = m;
      axi_wr(OFS_CONTROL_MAIN, rd, resp);
      chk(resp, RESP_OKAY);
      rd = $urandom;
      rd[7:0] = l;
      axi_wr(OFS_LEVEL_SELECT, rd, resp);
      chk(resp, RESP_OKAY);
      repeat (5) @(posedge sys_clk);
      check_all();
    end
    // Byte 0 strobe low: write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    axi_wr(OFS_CONTROL_MAIN, 32'hff, resp);
    chk(resp, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    // Unmapped word must leave both registers alone
    axi_wr(8'h08, 32'hffffffff, resp);
    chk(resp, RESP_SLVERR);
    axi_rd(8'h08, rd, resp);
    chk(rd, 32'h0);
    chk(resp, RESP_SLVERR);
    check_all();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    m = 8'h00;
    l = 8'h00;
    repeat (5) @(posedge sys_clk);
    check_all();
    axi_wr(OFS_CONTROL_MAIN, 32'h0, resp);
    conclude();
  end
endmodule : testbench
